// [rtl/scan_ctrl_params.svh]
// Purpose: Offsets, fields and reset values of the scan request control
// Assumes: Register indices; byte address is four times the index
// Notes:   Behaviour
// Behaviour
// - Oversample code picks averaged acquisition count
// - Calibration scans ignore the oversample field
// - Auto balancing scans use sixteen-times oversampling
// - Path bit: 0 primary, 1 alternate selector
// - Balance switch diagnostic types override path bit
// - Order bit: 0 pyramid, 1 ramp
// - Comparator and calibration scans force pyramid
// - Auto balancing scans always use pyramid
// - Scan bit is self-clearing strobe, reads 0
// - Write without scan moves data, applies settings when idle
// - No launch while running or complete set
// - Refused request keeps bits, raises alert
// - Write without scan clears three flags
// - Self-test feeds test words instead of results
// - Self-test bypasses calibration: gain one, offset zero
// - Self-test ignored for calibration and balancing
// - Odd first argument feeds odd first conversion
// - Odd second argument feeds odd second conversion
// - Even first argument feeds even first conversion
// - Even second argument feeds even second conversion
// - Sequence type 011 is on-demand calibration
`ifndef SCAN_CTRL_PARAMS_SVH
`define SCAN_CTRL_PARAMS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_CTRL 8'h64
`define IDX_STATUS 8'h65
`define IDX_ARG_ODD_1 8'h67
`define IDX_ARG_ODD_2 8'h68
`define IDX_ARG_EVEN_1 8'h69
`define IDX_ARG_EVEN_2 8'h6A

// ----------------------------------------
// Control fields
// ----------------------------------------
`define F_SCAN 0
`define F_ORDER 1
`define F_PATH 2
`define F_OVS_LO 3
`define F_OVS_HI 5
`define F_TYPE_LO 6
`define F_TYPE_HI 8
`define F_TEST_EN 15

// ----------------------------------------
// Status fields
// ----------------------------------------
`define S_BUSY 0
`define S_DONE 1
`define S_OVERTIME 2
`define S_RESULTS 3
`define S_REFUSED 4

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define TYPE_COMP_BOTH 3'h1
`define TYPE_COMP_ONLY 3'h2
`define TYPE_CAL 3'h3
`define TYPE_SW_SHORT 3'h4
`define TYPE_SW_OPEN 3'h5
`define TYPE_ADC_ONLY 3'h0
`define OVS_BALANCE 3'h3
`define CTRL_RESET 16'h0000
`define ARG_RESET 16'h0000

`endif

// [rtl/scan_ctrl_pkg.sv]
// Purpose: Types shared by the scan request control
// Assumes: Nothing beyond the params header
// Notes:   Configuration travels as one packed struct
package scan_ctrl_pkg;

    // ----------------------------------------
    // Effective scan configuration
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] seq_type;    // Sequence type actually run
        logic [7:0] avg_count;   // Acquisitions averaged, 0 for calibration
        logic path_alt;          // 1 = alternate cell selector
        logic order_ramp;        // 1 = ramp order
        logic self_test;         // ALU fed from test arguments
    } scan_cfg_t;

    // Sequencer view of the control
    typedef enum logic {
        ST_IDLE,
        ST_RUNNING
    } scan_state_t;

endpackage : scan_ctrl_pkg

// [rtl/scan_ctrl.sv]
// Purpose: Scan request control with APB register access and ALU feed
// Assumes: Sequencer and converter logic on the same clock as i_clk
// Notes:   APB answers one cycle after setup; no wait states
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "scan_ctrl_params.svh"

module scan_ctrl
    import scan_ctrl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic i_clk,                 // 25 MHz clock
    input wire logic i_rst_n,               // Async reset, active low
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_auto_balance,        // Automated balancing mode active
    input wire logic i_seq_done,            // Sequencer finished, pulse
    input wire logic i_seq_overtime,        // Sequencer timed out, pulse
    input wire logic i_xfer_done,           // Results landed in data regs, pulse
    input wire logic i_conv_valid,          // Converter result strobe
    input wire logic i_conv_second,         // 1 = second conversion of sample
    input wire logic i_sample_odd,          // 1 = odd-numbered sample
    input wire logic [11:0] i_conv_data,    // Converter result
    output logic o_scan_start,              // Launch pulse to sequencer
    output logic o_data_move,               // Data transfer pulse
    output scan_cfg_t o_cfg,                // Configuration of running scan
    output logic o_cal_bypass,              // Gain 1.0, offset 0.0
    output logic [11:0] o_alu_data,         // Word fed to ALU
    output logic o_alu_valid                // Strobe for o_alu_data
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (ADDR_W < 10) begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Averaged acquisition count from the oversample code
    function automatic logic [7:0] avg_of(input logic [2:0] code);
        case (code)
            3'h0: avg_of = 8'h01;
            3'h1: avg_of = 8'h04;
            3'h2: avg_of = 8'h08;
            3'h3: avg_of = 8'h10;
            3'h4: avg_of = 8'h20;
            3'h5: avg_of = 8'h40;
            default: avg_of = 8'h80;   // 11x
        endcase
    endfunction : avg_of

    // Word address match against a register index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
    endfunction : hit

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [15:1] ctrl;            // Stored control bits, scan bit not kept
    logic [15:0] arg_odd_1;       // Enable bit 15 and argument
    logic [11:0] arg_odd_2;
    logic [11:0] arg_even_1;
    logic [11:0] arg_even_2;
    scan_state_t state;           // Running or idle
    logic flag_done;              // Sequence complete
    logic flag_overtime;          // Sequence timed out
    logic flag_results;           // Results available
    logic flag_refused;           // Request refused alert

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic setup;                  // Setup cycle of a transfer
    logic wr_en;                  // Write takes effect this edge
    logic ctrl_wr;                // Control register written
    logic scan_req;               // Write asks for a scan
    logic accept;                 // Request launches a scan
    logic mapped;                 // Address names a register
    logic [2:0] w_type;           // Sequence type being written
    logic w_test;                 // Self-test bit currently held

    assign setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
    assign ctrl_wr = wr_en && hit(i_paddr, `IDX_CTRL);
    assign scan_req = ctrl_wr && i_pwdata[`F_SCAN];
    // Busy or an unread completion both block a new launch
    assign accept = scan_req && (state == ST_IDLE) && !flag_done;
    assign mapped = hit(i_paddr, `IDX_CTRL) || hit(i_paddr, `IDX_STATUS)
        || hit(i_paddr, `IDX_ARG_ODD_1) || hit(i_paddr, `IDX_ARG_ODD_2)
        || hit(i_paddr, `IDX_ARG_EVEN_1) || hit(i_paddr, `IDX_ARG_EVEN_2);
    assign w_type = i_pwdata[`F_TYPE_HI:`F_TYPE_LO];
    assign w_test = arg_odd_1[`F_TEST_EN];

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    // Ready comes one cycle after setup, so every access has one wait-free phase
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && !mapped;   // Unmapped answers with error
        end
    end

    // Read data captured in setup; the scan bit always reads 0
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            if (hit(i_paddr, `IDX_CTRL)) begin
                o_prdata <= {16'h0000, ctrl, 1'b0};
            end else if (hit(i_paddr, `IDX_STATUS)) begin
                o_prdata <= {27'h0, flag_refused, flag_results,
                    flag_overtime, flag_done, state == ST_RUNNING};
            end else if (hit(i_paddr, `IDX_ARG_ODD_1)) begin
                o_prdata <= {16'h0000, arg_odd_1[15], 3'h0, arg_odd_1[11:0]};
            end else if (hit(i_paddr, `IDX_ARG_ODD_2)) begin
                o_prdata <= {20'h00000, arg_odd_2};
            end else if (hit(i_paddr, `IDX_ARG_EVEN_1)) begin
                o_prdata <= {20'h00000, arg_even_1};
            end else if (hit(i_paddr, `IDX_ARG_EVEN_2)) begin
                o_prdata <= {20'h00000, arg_even_2};
            end else begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Control and argument registers
    // ----------------------------------------
    // Bits 15:1 land on every control write, refused or not
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= 15'(`CTRL_RESET >> 1);
        end else if (ctrl_wr) begin
            ctrl <= i_pwdata[15:1];
        end
    end

    // Test arguments; reserved bits are not stored
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arg_odd_1 <= `ARG_RESET;
            arg_odd_2 <= 12'h000;
            arg_even_1 <= 12'h000;
            arg_even_2 <= 12'h000;
        end else if (wr_en) begin
            if (hit(i_paddr, `IDX_ARG_ODD_1)) begin
                arg_odd_1 <= {i_pwdata[15], 3'h0, i_pwdata[11:0]};
            end
            if (hit(i_paddr, `IDX_ARG_ODD_2)) begin
                arg_odd_2 <= i_pwdata[11:0];
            end
            if (hit(i_paddr, `IDX_ARG_EVEN_1)) begin
                arg_even_1 <= i_pwdata[11:0];
            end
            if (hit(i_paddr, `IDX_ARG_EVEN_2)) begin
                arg_even_2 <= i_pwdata[11:0];
            end
        end
    end

    // ----------------------------------------
    // Scan state
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state <= ST_RUNNING;
                    end
                end
                ST_RUNNING: begin
                    if (i_seq_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Status write of 0 to a flag bit clears it; hardware set wins
    logic stat_wr;
    logic plain_ctrl_wr;          // Control write without scan request
    assign stat_wr = wr_en && hit(i_paddr, `IDX_STATUS);
    assign plain_ctrl_wr = ctrl_wr && !i_pwdata[`F_SCAN];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_done <= 1'b0;
        end else if (state == ST_RUNNING && i_seq_done) begin
            flag_done <= 1'b1;
        end else if (plain_ctrl_wr || (stat_wr && !i_pwdata[`S_DONE])) begin
            flag_done <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_overtime <= 1'b0;
        end else if (i_seq_overtime) begin
            flag_overtime <= 1'b1;
        end else if (plain_ctrl_wr || (stat_wr && !i_pwdata[`S_OVERTIME])) begin
            flag_overtime <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_results <= 1'b0;
        end else if (i_xfer_done) begin
            flag_results <= 1'b1;
        end else if (plain_ctrl_wr || (stat_wr && !i_pwdata[`S_RESULTS])) begin
            flag_results <= 1'b0;
        end
    end

    // Refused alert stays until software clears it in status
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_refused <= 1'b0;
        end else if (scan_req && !accept) begin
            flag_refused <= 1'b1;
        end else if (stat_wr && !i_pwdata[`S_REFUSED]) begin
            flag_refused <= 1'b0;
        end
    end

    // ----------------------------------------
    // Effective configuration
    // ----------------------------------------
    // Built from the write itself so the launch sees the new settings
    scan_cfg_t next_cfg;
    always_comb begin
        next_cfg.seq_type = i_auto_balance ? `TYPE_ADC_ONLY : w_type;
        if (i_auto_balance) begin
            next_cfg.avg_count = avg_of(`OVS_BALANCE);
        end else if (w_type == `TYPE_CAL) begin
            next_cfg.avg_count = 8'h00;
        end else begin
            next_cfg.avg_count = avg_of(i_pwdata[`F_OVS_HI:`F_OVS_LO]);
        end
        // Switch diagnostics set their own path
        if (!i_auto_balance && (w_type == `TYPE_SW_SHORT || w_type == `TYPE_SW_OPEN)) begin
            next_cfg.path_alt = 1'b1;
        end else begin
            next_cfg.path_alt = i_pwdata[`F_PATH];
        end
        if (i_auto_balance) begin
            next_cfg.order_ramp = 1'b0;
        end else if (w_type == `TYPE_CAL || w_type == `TYPE_COMP_BOTH
                || w_type == `TYPE_COMP_ONLY) begin
            next_cfg.order_ramp = 1'b0;
        end else begin
            next_cfg.order_ramp = i_pwdata[`F_ORDER];
        end
        next_cfg.self_test = w_test && !i_auto_balance && (w_type != `TYPE_CAL);
    end

    // Settings apply on any accepted control write, never mid-scan
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg <= '0;
            o_cal_bypass <= 1'b0;
        end else if (ctrl_wr && (state == ST_IDLE) && (!scan_req || accept)) begin
            o_cfg <= next_cfg;
            o_cal_bypass <= next_cfg.self_test;
        end
    end

    // ----------------------------------------
    // Launch and data move strobes
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_scan_start <= 1'b0;
            o_data_move <= 1'b0;
        end else begin
            o_scan_start <= accept;
            o_data_move <= ctrl_wr;
        end
    end

    // ----------------------------------------
    // ALU feed
    // ----------------------------------------
    // One cycle behind the converter strobe, same for both sources
    logic [11:0] test_word;
    always_comb begin
        case ({i_sample_odd, i_conv_second})
            2'b10: test_word = arg_odd_1[11:0];
            2'b11: test_word = arg_odd_2;
            2'b00: test_word = arg_even_1;
            default: test_word = arg_even_2;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alu_data <= 12'h000;
            o_alu_valid <= 1'b0;
        end else begin
            o_alu_valid <= i_conv_valid;
            if (i_conv_valid) begin
                o_alu_data <= o_cfg.self_test ? test_word : i_conv_data;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    busy_refuse_a: assert property (scan_req && state == ST_RUNNING |=>
        !o_scan_start && flag_refused) else $error("scan launched while busy");
    done_refuse_a: assert property (scan_req && flag_done |=>
        !o_scan_start) else $error("scan launched with complete flag set");
    start_running_a: assert property (o_scan_start |-> state == ST_RUNNING)
        else $error("start without running state");
    plain_clear_a: assert property (plain_ctrl_wr && !i_xfer_done |=>
        !flag_results) else $error("results flag not cleared");
    keep_bits_a: assert property (ctrl_wr |=> ctrl == $past(i_pwdata[15:1]))
        else $error("control bits not stored");
    balance_order_a: assert property (accept && i_auto_balance |=>
        !o_cfg.order_ramp && o_cfg.seq_type == `TYPE_ADC_ONLY && !o_cfg.self_test
        && !o_cal_bypass) else $error("balancing scan order or type wrong");
    cal_order_a: assert property (accept && !i_auto_balance && w_type == `TYPE_CAL |=>
        !o_cfg.order_ramp && o_cfg.avg_count == 8'h00 && !o_cfg.self_test)
        else $error("calibration scan not forced");
    bal_cfg_a: assert property (accept && i_auto_balance |=>
        o_cfg.avg_count == 8'h10 && !o_cfg.order_ramp)
        else $error("balancing scan configuration wrong");
    feed_test_a: assert property (i_conv_valid && o_cfg.self_test
        && i_sample_odd && !i_conv_second && $stable(o_cfg) |=>
        o_alu_valid && o_alu_data == $past(arg_odd_1[11:0]))
        else $error("test word not fed");
    no_start_a: assert property (plain_ctrl_wr |=> !o_scan_start ##1
        !o_scan_start || $past(accept)) else $error("plain write started scan");

    cov_accept_c: cover property (accept ##[1:50] i_seq_done);
    cov_refuse_c: cover property (scan_req && !accept);
    cov_test_c: cover property (o_alu_valid && o_cfg.self_test);

endmodule : scan_ctrl

// [sim/scan_ctrl_tb.sv]
// Purpose: Self-checking bench for the scan request control
// Assumes: APB answers without waits; strobes are one-cycle pulses
// Notes:   Bench drives every input itself; expected values come from rules
`timescale 1ns/1ps
`include "scan_ctrl_params.svh"

module tb import scan_ctrl_pkg::*; ;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic i_auto_balance = 1'b0, i_seq_done = 1'b0, i_seq_overtime = 1'b0, i_xfer_done = 1'b0;
    logic i_conv_valid = 1'b0, i_conv_second = 1'b0, i_sample_odd = 1'b0;
    logic [11:0] i_conv_data = 12'h000;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_scan_start, o_data_move, o_cal_bypass, o_alu_valid;
    logic [11:0] o_alu_data;
    scan_cfg_t o_cfg;
    int errors = 0;
    int comparisons = 0;
    int starts = 0;  // Launch pulses seen
    int moves = 0;   // Data transfer pulses seen
    logic [31:0] rv;
    logic ev;

    scan_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_auto_balance(i_auto_balance),
        .i_seq_done(i_seq_done), .i_seq_overtime(i_seq_overtime), .i_xfer_done(i_xfer_done),
        .i_conv_valid(i_conv_valid), .i_conv_second(i_conv_second),
        .i_sample_odd(i_sample_odd), .i_conv_data(i_conv_data), .o_scan_start(o_scan_start),
        .o_data_move(o_data_move), .o_cfg(o_cfg), .o_cal_bypass(o_cal_bypass),
        .o_alu_data(o_alu_data), .o_alu_valid(o_alu_valid));

    // ----------------------------------------
    // Clock, pulse counters and helpers
    // ----------------------------------------
    always #20 i_clk = ~i_clk;

    // Counting pulses spares each scenario from guessing the exact cycle
    always @(posedge i_clk) begin
        if (o_scan_start === 1'b1) starts++;
        if (o_data_move === 1'b1) moves++;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= {2'b00, idx, 2'b00};
        i_pwdata <= {16'h0000, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rv = o_prdata;
        ev = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk(nm, exp, rv);
    endtask : rd

    // Control write followed by a pause for the registered outputs
    task automatic ctl(input logic [2:0] t, input logic [2:0] o, input logic [2:0] pms);
        apb(1'b1, `IDX_CTRL, {7'h00, t, o, pms});
        repeat (3) @(posedge i_clk);
    endtask : ctl

    task automatic hw(input logic [2:0] v);
        @(posedge i_clk);
        {i_seq_done, i_seq_overtime, i_xfer_done} <= v;
        @(posedge i_clk);
        {i_seq_done, i_seq_overtime, i_xfer_done} <= 3'h0;
        @(posedge i_clk);
    endtask : hw

    task automatic conv(input logic sec, input logic odd, input logic [11:0] exp);
        @(posedge i_clk);
        i_conv_valid <= 1'b1;
        i_conv_second <= sec;
        i_sample_odd <= odd;
        i_conv_data <= 12'h5A5;
        @(posedge i_clk);
        i_conv_valid <= 1'b0;
        @(negedge i_clk);
        chk("alu valid", 32'h1, {31'h0, o_alu_valid});
        chk("alu data", {20'h0, exp}, {20'h0, o_alu_data});
    endtask : conv

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset();
        rd("ctrl reset", `IDX_CTRL, 32'h0);
        rd("status reset", `IDX_STATUS, 32'h0);
        rd("arg reset", `IDX_ARG_ODD_1, 32'h0);
        rd("unmapped", 8'h66, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, ev});
    endtask : s_reset

    task automatic s_avg();
        logic [7:0] tab [8] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h80};
        int m;
        int s;
        m = moves;
        s = starts;
        for (int k = 0; k < 8; k++) begin
            ctl(3'h0, 3'(k), 3'h0);
            chk("avg", {24'h0, tab[k]}, {24'h0, o_cfg.avg_count});
        end
        chk("moves", 32'(m + 8), 32'(moves));
        chk("no start", 32'(s), 32'(starts));
    endtask : s_avg

    task automatic s_scan();
        int s;
        s = starts;
        ctl(3'h0, 3'h2, 3'h7);
        chk("cfg", {18'h0, scan_cfg_t'({3'h0, 8'h08, 1'b1, 1'b1, 1'b0})}, {18'h0, o_cfg});
        chk("start", 32'(s + 1), 32'(starts));
        rd("running", `IDX_STATUS, 32'h01);
        rd("ctrl rd", `IDX_CTRL, 32'h16);
        ctl(3'h0, 3'h3, 3'h1);
        chk("busy refused", 32'(s + 1), 32'(starts));
        chk("cfg kept", 32'h8, {24'h0, o_cfg.avg_count});
        rd("alert", `IDX_STATUS, 32'h11);
        rd("bits kept", `IDX_CTRL, 32'h18);
        hw(3'b100);
        rd("done", `IDX_STATUS, 32'h12);
        ctl(3'h0, 3'h0, 3'h1);
        chk("done refused", 32'(s + 1), 32'(starts));
        hw(3'b011);
        rd("flags", `IDX_STATUS, 32'h1E);
        ctl(3'h0, 3'h0, 3'h0);
        rd("flags clr", `IDX_STATUS, 32'h10);
        apb(1'b1, `IDX_STATUS, 16'h0000);
        rd("alert clr", `IDX_STATUS, 32'h0);
    endtask : s_scan

    task automatic s_types();
        int s;
        for (int t = 1; t < 4; t++) begin
            ctl(3'(t), 3'h5, 3'h2);
            chk("pyramid", 32'h0, {31'h0, o_cfg.order_ramp});
            chk("cal avg", (t == 3) ? 32'h0 : 32'h40, {24'h0, o_cfg.avg_count});
        end
        // Enter the diagnostic with a plain write, then request the scan later
        for (int t = 4; t < 6; t++) begin
            ctl(3'(t), 3'h0, 3'h0);
            chk("diag path", 32'h1, {31'h0, o_cfg.path_alt});
            s = starts;
            ctl(3'(t), 3'h0, 3'h1);
            chk("diag start", 32'(s + 1), 32'(starts));
            chk("diag scan path", 32'h1, {31'h0, o_cfg.path_alt});
            hw(3'b100);
            ctl(3'h0, 3'h0, 3'h0);
        end
    endtask : s_types

    task automatic s_test();
        logic [11:0] arg [4] = '{12'hABC, 12'h123, 12'h456, 12'h789};
        int s;
        apb(1'b1, `IDX_ARG_ODD_1, 16'h8ABC);
        apb(1'b1, `IDX_ARG_ODD_2, 16'h0123);
        apb(1'b1, `IDX_ARG_EVEN_1, 16'h0456);
        apb(1'b1, `IDX_ARG_EVEN_2, 16'h0789);
        rd("arg rd", `IDX_ARG_ODD_1, 32'h8ABC);
        ctl(3'h0, 3'h1, 3'h0);
        chk("self test", 32'h1, {31'h0, o_cfg.self_test});
        chk("bypass", 32'h1, {31'h0, o_cal_bypass});
        // Index bit 0 picks the second conversion, bit 1 an even sample
        for (int k = 0; k < 4; k++) begin
            conv(k[0], ~k[1], arg[k]);
        end
        s = starts;
        ctl(3'h3, 3'h0, 3'h1);
        chk("cal start", 32'(s + 1), 32'(starts));
        chk("cal no test", 32'h0, {31'h0, o_cfg.self_test});
        hw(3'b100);
        ctl(3'h0, 3'h0, 3'h0);
        i_auto_balance <= 1'b1;
        ctl(3'h5, 3'h6, 3'h7);
        // Path bit is left out: balancing fixes type, count, order and self-test only
        chk("bal cfg", 32'h0080, {18'h0, o_cfg} & 32'h3FFB);
        hw(3'b100);
        i_auto_balance <= 1'b0;
        apb(1'b1, `IDX_ARG_ODD_1, 16'h0000);
        ctl(3'h0, 3'h0, 3'h0);
        conv(1'b0, 1'b1, 12'h5A5);
    endtask : s_test

    task automatic close_out();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        s_reset();
        s_avg();
        s_scan();
        s_types();
        s_test();
        close_out();
    end

    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #(40 * 5000);
        errors++;
        close_out();
    end
endmodule : tb
